//--- design/per_event_router.sv
// Event channel multiplexers, synchronisers and user selectors
//
// Summary of operation
// - Interval taps divide timebase by 8192 down to 64
// - Serial bit clocks routed as synchronous levels
// - Lookup table outputs routed as asynchronous levels
// - Comparator level routed asynchronously, no clocking
// - Zero-cross level routed asynchronously, no clocking
// - Each user selects its own channel
// - Asynchronous lookup and pin users work with clocks stopped; async edge and level users need mclk
// - Asynchronous lookup and pin users may react between clock edges
// - Synchronous edge user needs clocked source
// - Asynchronous edge user uses internal synchroniser
// - Synchronous level user needs clocked source
// - Asynchronous level user uses internal synchroniser
// - Undetected users take the raw channel
// - Lookup table inputs take channel asynchronously
// - Event pin forwards channel unchanged
// - Async sources synchronised, two mclk edges
// - Software event inverts channel for one cycle
// - After reset channels have no generator
`timescale 1ns/1ps
`include "per_regs.svh"

module per_event_router
	import per_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic timebase_clk,
	input wire per_gen_in_t gen_in,
	input wire per_gen_sel_t chan_sel_in [`PER_NUM_CH],
	input wire per_usr_sel_t user_sel_in [`PER_NUM_USR],
	input wire logic [`PER_NUM_CH-1:0] sw_event_in,
	output logic [1:0] lut_input_evt,
	output logic [1:0] event_pin_output,
	output logic adc_start_pulse,
	output logic sync_edge_pulse,
	output logic sync_level_evt,
	output logic async_level_evt,
	output logic [`PER_NUM_CH-1:0] ch_async_sub,
	output logic [`PER_NUM_CH-1:0] ch_sync_sub
);

	logic tb_s1_reg;
	logic tb_s2_reg;
	logic tb_s3_reg;
	logic [`PER_TAP_CNT_W-1:0] tap_cnt_reg;
	logic [`PER_TAP_CNT_W-1:0] tap_cnt_next;
	logic [`PER_NUM_CH-1:0] sw_reg;
	logic [`PER_NUM_CH-1:0] ch_raw;
	logic [`PER_NUM_CH-1:0] ch_is_async;
	logic [`PER_NUM_CH-1:0] ch_s1_reg;
	logic [`PER_NUM_CH-1:0] ch_s2_reg;
	logic [`PER_NUM_GEN-1:0] gen_vec;
	logic [`PER_NUM_USR-1:0] usr_async;
	logic [`PER_NUM_USR-1:0] usr_sync;
	logic [2:0] adc_sync_reg;
	logic [1:0] alvl_sync_reg;
	logic sedge_prev_reg;
	per_gen_sel_t chan_sel_reg [`PER_NUM_CH];
	per_usr_sel_t user_sel_reg [`PER_NUM_USR];
	wire tap_tick = tb_s2_reg & ~tb_s3_reg;
	wire [7:0] taps = tap_cnt_reg[`PER_TAP_CNT_W-1:`PER_TAP_LOW_BIT];

	// Timebase is foreign; count its rising edges after a two-stage synchroniser
	always_ff @(posedge mclk)
	begin
		tb_s1_reg <= reset ? 1'b0 : timebase_clk;
		tb_s2_reg <= reset ? 1'b0 : tb_s1_reg;
		tb_s3_reg <= reset ? 1'b0 : tb_s2_reg;
	end

	assign tap_cnt_next = tap_tick ? tap_cnt_reg + 13'h0001 : tap_cnt_reg;

	always_ff @(posedge mclk)
	begin
		tap_cnt_reg <= reset ? 13'h0000 : tap_cnt_next;
	end

	// Counter bit k toggles every 2^k ticks: bit 12 gives /8192, bit 5 gives /64
	assign gen_vec = {
		gen_in.compare_match_event,
		gen_in.overflow_event,
		gen_in.conversion_result_done,
		gen_in.pin_level,
		gen_in.zero_cross_detector,
		gen_in.analog_comparator,
		gen_in.lookup_table_output,
		gen_in.serial_bit_clock_spi,
		gen_in.serial_bit_clock_usart,
		taps[0], taps[1], taps[2], taps[3], taps[4], taps[5], taps[6], taps[7],
		1'b0
	};

	always_ff @(posedge mclk)
	begin
		sw_reg <= reset ? 10'h000 : sw_event_in;
	end

	genvar c;
	generate
		for (c = 0; c < `PER_NUM_CH; c++)
		begin : g_ch
			wire sel_ok = chan_sel_reg[c] < `PER_NUM_GEN;
			wire [`PER_NUM_GEN-1:0] async_mask = `PER_GEN_ASYNC_MASK;

			always_ff @(posedge mclk)
			begin
				chan_sel_reg[c] <= reset ? `PER_GEN_NONE : chan_sel_in[c];
			end

			assign ch_raw[c] = sel_ok & gen_vec[chan_sel_reg[c]];
			assign ch_is_async[c] = sel_ok & async_mask[chan_sel_reg[c]];

			// The first stage feeds only the second; metastability stays contained
			always_ff @(posedge mclk)
			begin
				ch_s1_reg[c] <= reset ? 1'b0 : ch_raw[c];
				ch_s2_reg[c] <= reset ? 1'b0 : ch_s1_reg[c];
			end

			// No clock in the async path, so it works asleep and between edges
			assign ch_async_sub[c] = ch_raw[c] ^ sw_reg[c];
			assign ch_sync_sub[c] = (ch_is_async[c] ? ch_s2_reg[c] : ch_raw[c]) ^ sw_reg[c];
		end
	endgenerate

	genvar u;
	generate
		for (u = 0; u < `PER_NUM_USR; u++)
		begin : g_usr
			wire pick = (user_sel_reg[u] != 4'h0) && (user_sel_reg[u] <= `PER_NUM_CH);
			wire [3:0] idx = user_sel_reg[u] - 4'h1;

			always_ff @(posedge mclk)
			begin
				user_sel_reg[u] <= reset ? 4'h0 : user_sel_in[u];
			end

			assign usr_async[u] = pick & ch_async_sub[idx];
			assign usr_sync[u] = pick & ch_sync_sub[idx];
		end
	endgenerate

	// Raw users are wires by nature; registering them would break sleep operation
	assign lut_input_evt = usr_async[`PER_USR_LUT_IN1:`PER_USR_LUT_IN0];
	assign event_pin_output = usr_async[`PER_USR_PIN_OUT1:`PER_USR_PIN_OUT0];

	always_ff @(posedge mclk)
	begin
		adc_sync_reg <= reset ? 3'h0 : {adc_sync_reg[1:0], usr_async[`PER_USR_ADC_START]};
		alvl_sync_reg <= reset ? 2'h0 : {alvl_sync_reg[0], usr_async[`PER_USR_ASYNC_LEVEL]};
		sedge_prev_reg <= reset ? 1'b0 : usr_sync[`PER_USR_SYNC_EDGE];
		sync_edge_pulse <= ~reset & usr_sync[`PER_USR_SYNC_EDGE] & ~sedge_prev_reg;
		sync_level_evt <= ~reset & usr_sync[`PER_USR_SYNC_LEVEL];
		adc_start_pulse <= ~reset & adc_sync_reg[1] & ~adc_sync_reg[2];
		async_level_evt <= ~reset & alvl_sync_reg[1];
	end

	property p_tap_count;
		@(posedge mclk) disable iff (reset)
		tap_tick |=> tap_cnt_reg == $past(tap_cnt_reg) + 13'h0001;
	endproperty
	a_tap_count: assert property (p_tap_count) else $error("tap counter missed a tick");

	property p_sck_sync;
		@(posedge mclk) disable iff (reset)
		chan_sel_reg[1] == `PER_GEN_SCK_SPI && !sw_reg[1]
			|-> ch_sync_sub[1] == gen_in.serial_bit_clock_spi;
	endproperty
	a_sck_sync: assert property (p_sck_sync) else $error("serial clock not on sync channel");

	property p_lut_async;
		@(posedge mclk) disable iff (reset)
		chan_sel_reg[0] == `PER_GEN_LUT0 && !sw_reg[0]
			|-> ch_async_sub[0] == gen_in.lookup_table_output[0];
	endproperty
	a_lut_async: assert property (p_lut_async) else $error("lookup output not passed raw");

	property p_acmp_async;
		@(posedge mclk) disable iff (reset)
		chan_sel_reg[0] == `PER_GEN_ACMP && !sw_reg[0]
			|-> ch_async_sub[0] == gen_in.analog_comparator;
	endproperty
	a_acmp_async: assert property (p_acmp_async) else $error("comparator not passed raw");

	property p_zcd_async;
		@(posedge mclk) disable iff (reset)
		chan_sel_reg[0] == `PER_GEN_ZCD && !sw_reg[0]
			|-> ch_async_sub[0] == gen_in.zero_cross_detector;
	endproperty
	a_zcd_async: assert property (p_zcd_async) else $error("zero-cross not passed raw");

	property p_sync_delay;
		@(posedge mclk) disable iff (reset)
		($rose(ch_raw[0]) && ch_is_async[0]) ##1 (ch_raw[0] && ch_is_async[0] && !sw_reg[0]) [*2]
			|-> ch_sync_sub[0];
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("async event not synchronised");

	property p_sw_invert;
		@(posedge mclk) disable iff (reset)
		sw_event_in[3] |=> ch_async_sub[3] != ch_raw[3];
	endproperty
	a_sw_invert: assert property (p_sw_invert) else $error("software event did not invert");

	property p_sw_one;
		@(posedge mclk) disable iff (reset)
		!sw_event_in[3] |=> ch_async_sub[3] == ch_raw[3];
	endproperty
	a_sw_one: assert property (p_sw_one) else $error("inversion lasted too long");

	property p_reset_none;
		@(posedge mclk)
		$fell(reset) |-> chan_sel_reg[0] == `PER_GEN_NONE && !ch_async_sub[0];
	endproperty
	a_reset_none: assert property (p_reset_none) else $error("channel connected after reset");

	property p_none_low;
		@(posedge mclk) disable iff (reset)
		chan_sel_reg[1] == `PER_GEN_NONE && !sw_reg[1] |-> !ch_async_sub[1] && !ch_sync_sub[1];
	endproperty
	a_none_low: assert property (p_none_low) else $error("unconnected channel not low");

	property p_sync_edge;
		@(posedge mclk) disable iff (reset)
		$rose(usr_sync[`PER_USR_SYNC_EDGE]) |=> sync_edge_pulse ##1 !sync_edge_pulse;
	endproperty
	a_sync_edge: assert property (p_sync_edge) else $error("sync edge user missed edge");

	property p_sync_level;
		@(posedge mclk) disable iff (reset)
		1'b1 |=> sync_level_evt == $past(usr_sync[`PER_USR_SYNC_LEVEL]);
	endproperty
	a_sync_level: assert property (p_sync_level) else $error("sync level user wrong");

	property p_adc_edge;
		@(posedge mclk) disable iff (reset)
		!usr_async[`PER_USR_ADC_START] ##1 usr_async[`PER_USR_ADC_START] [*4]
			|-> ##[0:1] adc_start_pulse;
	endproperty
	a_adc_edge: assert property (p_adc_edge) else $error("async edge user missed edge");

	property p_async_level;
		@(posedge mclk) disable iff (reset)
		usr_async[`PER_USR_ASYNC_LEVEL] [*4] |-> async_level_evt;
	endproperty
	a_async_level: assert property (p_async_level) else $error("async level user missed level");

	property p_user_none;
		@(posedge mclk) disable iff (reset)
		user_sel_reg[`PER_USR_PIN_OUT0] == 4'h0 |-> !event_pin_output[0];
	endproperty
	a_user_none: assert property (p_user_none) else $error("unselected user saw event");

	property p_pin_fwd;
		@(posedge mclk) disable iff (reset)
		user_sel_reg[`PER_USR_PIN_OUT1] == 4'h1 |-> event_pin_output[1] == ch_async_sub[0];
	endproperty
	a_pin_fwd: assert property (p_pin_fwd) else $error("pin output not forwarded");

	property p_lut_in;
		@(posedge mclk) disable iff (reset)
		user_sel_reg[`PER_USR_LUT_IN0] == 4'h2 |-> lut_input_evt[0] == ch_async_sub[1];
	endproperty
	a_lut_in: assert property (p_lut_in) else $error("lookup input not raw channel");

endmodule : per_event_router

//--- shared/per_regs.svh
// Constants for the peripheral event routing network
`ifndef PER_REGS_SVH
`define PER_REGS_SVH
`define PER_NUM_CH 10
`define PER_NUM_USR 8
`define PER_NUM_GEN 20
`define PER_GEN_W 5
`define PER_USR_W 4
`define PER_TAP_CNT_W 13
`define PER_TAP_MAX_DIV 8192
`define PER_TAP_MIN_DIV 64
`define PER_TAP_LOW_BIT 5
`define PER_GEN_NONE 5'h00
`define PER_GEN_TAP0 5'h01
`define PER_GEN_SCK_USART 5'h09
`define PER_GEN_SCK_SPI 5'h0A
`define PER_GEN_LUT0 5'h0B
`define PER_GEN_LUT1 5'h0C
`define PER_GEN_ACMP 5'h0D
`define PER_GEN_ZCD 5'h0E
`define PER_GEN_PIN0 5'h0F
`define PER_GEN_PIN1 5'h10
`define PER_GEN_ADC_DONE 5'h11
`define PER_GEN_OVF 5'h12
`define PER_GEN_CMP 5'h13
`define PER_GEN_ASYNC_MASK 20'h1F800
`define PER_USR_LUT_IN0 0
`define PER_USR_LUT_IN1 1
`define PER_USR_PIN_OUT0 2
`define PER_USR_PIN_OUT1 3
`define PER_USR_ADC_START 4
`define PER_USR_SYNC_EDGE 5
`define PER_USR_SYNC_LEVEL 6
`define PER_USR_ASYNC_LEVEL 7
`endif

//--- shared/per_pkg.sv
// Types for the peripheral event routing network
package per_pkg;
	typedef struct packed {
		logic serial_bit_clock_usart;
		logic serial_bit_clock_spi;
		logic [1:0] lookup_table_output;
		logic analog_comparator;
		logic zero_cross_detector;
		logic [1:0] pin_level;
		logic conversion_result_done;
		logic overflow_event;
		logic compare_match_event;
	} per_gen_in_t;
	typedef logic [4:0] per_gen_sel_t;
	typedef logic [3:0] per_usr_sel_t;
endpackage : per_pkg

//--- bench/per_gen_model.sv
// Event generator model: a clocked serial clock and unclocked comparator-derived levels
`timescale 1ns/1ps
module per_gen_model
	import per_pkg::*;
(
	input wire logic mclk,
	input wire logic spi_run,
	input wire logic cmp_level,
	output per_gen_in_t gen_in
);
	logic [1:0] div_reg = 2'h0;
	logic sck_reg = 1'b0;
	logic cmp_async;
	// Serial clock built from mclk, each level held two cycles
	always @(posedge mclk)
	begin
		div_reg <= spi_run ? div_reg + 2'h1 : 2'h0;
		if (div_reg[0])
			sck_reg <= ~sck_reg;
	end
	// Comparator moves between clock edges, held much longer than one cycle
	assign #13 cmp_async = cmp_level;
	always_comb
	begin
		gen_in = '0;
		gen_in.serial_bit_clock_spi = sck_reg;
		gen_in.analog_comparator = cmp_async;
		gen_in.lookup_table_output = {1'b0, cmp_async};
		gen_in.zero_cross_detector = ~cmp_async;
	end
endmodule : per_gen_model

//--- bench/per_event_router_tb_top.sv
// Self-checking bench for the event routing network
`timescale 1ns/1ps
module per_event_router_tb_top
	import per_pkg::*;
;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic timebase_clk = 1'b0;
	logic spi_run = 1'b0;
	logic cmp_level = 1'b0;
	per_gen_in_t gen_in;
	per_gen_sel_t chan_sel [10];
	per_usr_sel_t user_sel [8];
	logic [9:0] sw_ev = 10'h000;
	logic [1:0] lut_o, pin_o;
	logic adc_o, edge_o, slev_o, alev_o;
	logic [9:0] asub, ssub;
	int n_mismatch = 0;
	int n_compared = 0;
	always #25 mclk = ~mclk;
	// Unrelated to mclk so the tap synchroniser sees drifting phase
	always #55 timebase_clk = ~timebase_clk;
	per_gen_model gen_u (.mclk(mclk), .spi_run(spi_run), .cmp_level(cmp_level), .gen_in(gen_in));
	per_event_router dut_u (.mclk(mclk), .reset(reset), .timebase_clk(timebase_clk),
		.gen_in(gen_in), .chan_sel_in(chan_sel), .user_sel_in(user_sel), .sw_event_in(sw_ev),
		.lut_input_evt(lut_o), .event_pin_output(pin_o), .adc_start_pulse(adc_o),
		.sync_edge_pulse(edge_o), .sync_level_evt(slev_o), .async_level_evt(alev_o),
		.ch_async_sub(asub), .ch_sync_sub(ssub));
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic t_async();
		@(posedge mclk)
		begin
			chan_sel[0] <= 5'h0D;
			user_sel[0] <= 4'h1;
			user_sel[2] <= 4'h1;
			user_sel[3] <= 4'h1;
			user_sel[4] <= 4'h1;
			user_sel[7] <= 4'h1;
		end
		step(2);
		@(posedge mclk) cmp_level <= 1'b1;
		#20;
		chk({pin_o, lut_o, asub[0], ssub[0]}, 20'h36);
		step(2);
		chk({ssub[0], adc_o, alev_o}, 20'h4);
		step(1);
		chk({adc_o, alev_o}, 20'h3);
		step(1);
		chk({adc_o, alev_o}, 20'h1);
		@(posedge mclk) cmp_level <= 1'b0;
		step(5);
	endtask : t_async
	task automatic t_raw();
		@(posedge mclk)
		begin
			chan_sel[0] <= 5'h0B;
			cmp_level <= 1'b1;
		end
		step(2);
		chk({asub[0], ssub[0], pin_o, lut_o[0]}, 20'h1F);
		@(posedge mclk)
		begin
			chan_sel[0] <= 5'h0E;
			cmp_level <= 1'b0;
		end
		step(2);
		// Sync copy still shows the old source: the synchroniser lags two edges
		chk({asub[0], ssub[0], pin_o, lut_o[0]}, 20'h17);
		@(posedge mclk) chan_sel[0] <= 5'h0D;
		step(3);
	endtask : t_raw
	task automatic t_sw();
		@(posedge mclk)
		begin
			user_sel[5] <= 4'h4;
			user_sel[6] <= 4'h4;
		end
		@(posedge mclk) sw_ev <= 10'h008;
		@(posedge mclk) sw_ev <= 10'h000;
		#1;
		chk({asub, ssub}, {10'h008, 10'h008});
		step(1);
		chk({asub[3], ssub[3], edge_o, slev_o}, 20'h3);
		step(1);
		chk({edge_o, slev_o}, 20'h0);
	endtask : t_sw
	task automatic t_serial();
		logic p1, p2;
		@(posedge mclk)
		begin
			chan_sel[1] <= 5'h0A;
			user_sel[0] <= 4'h2;
			user_sel[5] <= 4'h2;
			spi_run <= 1'b1;
		end
		step(1);
		p1 = ssub[1];
		step(1);
		repeat (24)
		begin
			p2 = p1;
			p1 = ssub[1];
			step(1);
			chk({edge_o, asub[1]}, {p1 & ~p2, gen_in.serial_bit_clock_spi});
			chk({ssub[1], lut_o[0]}, {2{gen_in.serial_bit_clock_spi}});
			if (ssub[1] != p1)
				chk(p1 == p2, 1'b1);
		end
		@(posedge mclk) spi_run <= 1'b0;
	endtask : t_serial
	task automatic t_tap();
		int n;
		@(posedge mclk) chan_sel[2] <= 5'h08;
		for (n = 0; n < 400 && ssub[2] !== 1'b1; n++) step(1);
		for (n = 0; n < 400 && ssub[2] === 1'b1; n++) step(1);
		// Half period of the /64 tap is 32 timebase periods, about 70 mclk cycles
		chk(n >= 67 && n <= 74, 1'b1);
		if (n >= 400)
			end_sim();
	endtask : t_tap
	initial
	begin
		foreach (chan_sel[i]) chan_sel[i] = 5'h00;
		foreach (user_sel[i]) user_sel[i] = 4'h0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		step(1);
		chk({asub, ssub}, 20'h0);
		chk({lut_o, pin_o, adc_o, edge_o, slev_o, alev_o}, 20'h0);
		t_async();
		t_raw();
		t_sw();
		t_serial();
		t_tap();
		end_sim();
	end
endmodule : per_event_router_tb_top
